// ===== common/port_ctrl_pkg.sv
package port_ctrl_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [4:0] port_control_off = 5'h04;
	localparam logic [4:0] reserved_port_word_off = 5'h05;
	localparam int forced_pause_bit = 15;
	localparam int egress_trailer_bit = 14;
	localparam int header_bit = 11;
	localparam int ingress_trailer_bit = 8;
	localparam int bypass_bit = 7;
	localparam logic [15:0] writable_mask = 16'hc983;
	localparam logic [1:0] state_disabled = 2'h0;
	localparam logic [1:0] state_blocking = 2'h1;
	localparam logic [1:0] state_learning = 2'h2;
	localparam logic [1:0] state_forwarding = 2'h3;
	localparam logic [1:0] cpu_attached_mode = 2'h0;
	localparam int num_ports = 6;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] addr;
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic sof;
		logic eof;
		logic valid;
		logic dest_locked;
		logic dest_multicast;
		logic dest_control_plane_frame_entry;
		logic [5:0] dest_ports;
	} frame_info_s;
endpackage

// ===== hdl/port_ctrl_store.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// small register store: holds the control word with masked writes
// ----------------------------------------------------------------
module port_ctrl_store #(
	parameter int width = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// write side
	input wire logic wr_en,
	input wire logic [width-1:0] wr_mask,
	input wire logic [width-1:0] wr_data,
	input wire logic [width-1:0] reset_value,
	input wire logic load_reset,
	// read side
	output logic [width-1:0] q
);
	initial begin
		if (width < 1) $error("width must be positive");
	end

	// masked write; bits outside mask keep their value
	always_ff @(posedge sys_clk) begin
		if (!resetn || load_reset) begin
			q <= reset_value;
		end else if (wr_en) begin
			q <= (q & ~wr_mask) | (wr_data & wr_mask);
		end
	end
endmodule
`default_nettype wire

// ===== hdl/switch_port_control.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// per-port control logic of a small switch
// ----------------------------------------------------------------
module switch_port_control #(
	parameter int port_index = 0,
	parameter logic trailer_capable = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// management register port
	input wire port_ctrl_pkg::reg_req_s reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// straps and commands
	input wire logic [1:0] switch_config_pins,
	input wire logic strap_pause_enable,
	input wire logic soft_reset_cmd,
	input wire logic [5:0] egress_port_mask,
	// link status
	input wire logic duplex_full,
	input wire logic link_resolved,
	// ingress frame
	input wire port_ctrl_pkg::frame_info_s rx_frame,
	// egress frame
	input wire port_ctrl_pkg::frame_info_s tx_frame,
	// to forwarding core
	output logic rx_accept,
	output logic rx_learn,
	output logic [5:0] rx_dest_ports,
	output logic tx_accept,
	output logic tx_add_trailer,
	output logic rx_strip_trailer,
	output logic flow_control_en,
	output logic back_pressure_en,
	output logic queue_release,
	output logic [1:0] stp_port_state
);
	import port_ctrl_pkg::*;

	// all checks run on the core clock and rest while reset is low
	default clocking check_cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	typedef enum {idle_st, in_frame_st} frame_phase_e;

	initial begin
		if (port_index < 0 || port_index >= num_ports)
			$error("port_index out of range");
	end

	logic [15:0] ctrl_q;
	logic [15:0] ctrl_reset;
	logic [15:0] ctrl_wmask;
	logic ctrl_wr;
	logic [1:0] state_reset;
	logic [1:0] rx_state_reg;
	logic [1:0] tx_state_reg;
	frame_phase_e rx_phase_reg;
	frame_phase_e tx_phase_reg;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// control-plane frame: multicast destination with management entry
	function automatic logic is_ctrl_plane(input frame_info_s f);
		is_ctrl_plane = f.dest_multicast && f.dest_control_plane_frame_entry;
	endfunction

	// does a given state admit this frame
	function automatic logic state_admits(input logic [1:0] st,
		input frame_info_s f);
		case (st)
			state_disabled: state_admits = 1'b0;
			state_blocking: state_admits = is_ctrl_plane(f);
			state_learning: state_admits = is_ctrl_plane(f);
			default: state_admits = 1'b1;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// register store
	// ----------------------------------------------------------------
	// reset value depends on straps
	assign state_reset = (switch_config_pins == cpu_attached_mode) ?
		state_disabled : state_forwarding;
	assign ctrl_reset = {14'h0000, state_reset};
	assign ctrl_wr = reg_req.wr && (reg_req.addr == port_control_off);

	// pause bit writable only while disabled; reserved bits masked
	always_comb begin
		ctrl_wmask = writable_mask;
		if (ctrl_q[1:0] != state_disabled) begin
			ctrl_wmask[forced_pause_bit] = 1'b0;
		end
	end

	port_ctrl_store #(
		.width(16)
	) u_store (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.wr_en(ctrl_wr),
		.wr_mask(ctrl_wmask),
		.wr_data(reg_req.wdata),
		.reset_value(ctrl_reset),
		.load_reset(soft_reset_cmd),
		.q(ctrl_q)
	);

	// register read port
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd && reg_req.addr == port_control_off) begin
				reg_rdata <= ctrl_q & writable_mask;
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// frame boundary state capture
	// ----------------------------------------------------------------
	// ingress side: state latched at frame start keeps frames intact
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rx_phase_reg <= idle_st;
			rx_state_reg <= state_disabled;
		end else begin
			case (rx_phase_reg)
				idle_st: begin
					rx_state_reg <= ctrl_q[1:0];
					if (rx_frame.valid && rx_frame.sof && !rx_frame.eof)
						rx_phase_reg <= in_frame_st;
				end
				in_frame_st: begin
					if (rx_frame.valid && rx_frame.eof)
						rx_phase_reg <= idle_st;
				end
				default: rx_phase_reg <= idle_st;
			endcase
		end
	end

	// egress side: same frame-boundary capture
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tx_phase_reg <= idle_st;
			tx_state_reg <= state_disabled;
		end else begin
			case (tx_phase_reg)
				idle_st: begin
					tx_state_reg <= ctrl_q[1:0];
					if (tx_frame.valid && tx_frame.sof && !tx_frame.eof)
						tx_phase_reg <= in_frame_st;
				end
				in_frame_st: begin
					if (tx_frame.valid && tx_frame.eof)
						tx_phase_reg <= idle_st;
				end
				default: tx_phase_reg <= idle_st;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// frame decisions
	// ----------------------------------------------------------------
	logic [1:0] rx_eff_state;
	logic [1:0] tx_eff_state;
	logic [5:0] mask_eff;
	assign rx_eff_state = (rx_phase_reg == idle_st) ? ctrl_q[1:0] :
		rx_state_reg;
	assign tx_eff_state = (tx_phase_reg == idle_st) ? ctrl_q[1:0] :
		tx_state_reg;

	// egress mask, bypassed for locked destinations when enabled
	always_comb begin
		mask_eff = egress_port_mask;
		if (ctrl_q[bypass_bit] && rx_frame.dest_locked)
			mask_eff = 6'h3f;
	end

	// ingress admission and forwarding decision
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rx_accept <= 1'b0;
			rx_learn <= 1'b0;
			rx_dest_ports <= 6'h00;
		end else begin
			rx_accept <= rx_frame.valid &&
				state_admits(rx_eff_state, rx_frame);
			rx_learn <= rx_frame.valid &&
				(rx_eff_state == state_learning ||
				 rx_eff_state == state_forwarding);
			rx_dest_ports <= rx_frame.valid ?
				(rx_frame.dest_ports & mask_eff) : 6'h00;
		end
	end

	// egress admission and trailer controls
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tx_accept <= 1'b0;
			tx_add_trailer <= 1'b0;
			rx_strip_trailer <= 1'b0;
		end else begin
			tx_accept <= tx_frame.valid &&
				state_admits(tx_eff_state, tx_frame);
			tx_add_trailer <= trailer_capable &&
				ctrl_q[egress_trailer_bit];
			rx_strip_trailer <= trailer_capable &&
				ctrl_q[ingress_trailer_bit];
		end
	end

	// pause selection by duplex, queue release, state view
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			flow_control_en <= 1'b0;
			back_pressure_en <= 1'b0;
			queue_release <= 1'b0;
			stp_port_state <= 2'h0;
		end else begin
			flow_control_en <= link_resolved && duplex_full &&
				(ctrl_q[forced_pause_bit] || strap_pause_enable);
			back_pressure_en <= link_resolved && !duplex_full &&
				(ctrl_q[forced_pause_bit] || strap_pause_enable);
			queue_release <= (ctrl_q[1:0] == state_disabled);
			stp_port_state <= ctrl_q[1:0];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_pause_locked: assert property (
		ctrl_q[1:0] != state_disabled && !soft_reset_cmd |=>
		$stable(ctrl_q[forced_pause_bit]))
		else $error("pause bit changed outside disabled state");
	a_disabled_no_rx: assert property (
		rx_frame.valid && rx_eff_state == state_disabled |=> !rx_accept)
		else $error("frame accepted while disabled");
	a_blocking_ctrl: assert property (
		rx_frame.valid && rx_eff_state == state_blocking |=>
		rx_accept == ($past(rx_frame.dest_multicast) &&
		$past(rx_frame.dest_control_plane_frame_entry)) && !rx_learn)
		else $error("blocking state admission wrong");
	a_forward_all: assert property (
		rx_frame.valid && rx_eff_state == state_forwarding |=>
		rx_accept && rx_learn)
		else $error("forwarding state dropped frame");
	a_soft_reset: assert property (
		soft_reset_cmd |=> ctrl_q[1:0] == $past(state_reset))
		else $error("soft reset did not restore state");
	a_mask_applied: assert property (
		rx_frame.valid && !ctrl_q[bypass_bit] |=>
		rx_dest_ports ==
		($past(rx_frame.dest_ports) & $past(egress_port_mask)))
		else $error("egress mask not applied");
	a_mask_bypass: assert property (
		rx_frame.valid && ctrl_q[bypass_bit] && rx_frame.dest_locked |=>
		rx_dest_ports == $past(rx_frame.dest_ports))
		else $error("locked destination was masked");
	a_reserved_zero: assert property (
		reg_rvalid |-> (reg_rdata & ~writable_mask) == 16'h0000)
		else $error("reserved bits read nonzero");
	a_trailer_ports: assert property (
		!trailer_capable |-> !tx_add_trailer && !rx_strip_trailer)
		else $error("trailer on incapable port");
endmodule
`default_nettype wire

// ===== bench/fwd_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// forwarding core model: hands frame beats to the port logic
// ----------------------------------------------------------------
module fwd_core_model (
	// clock
	input wire logic sys_clk,
	// frame beats toward the port
	output var port_ctrl_pkg::frame_info_s rx_frame,
	output var port_ctrl_pkg::frame_info_s tx_frame
);
	import port_ctrl_pkg::*;
	// lines start idle
	initial begin
		rx_frame = '0;
		tx_frame = '0;
	end
	// one beat, then the released lines show the inverse
	task automatic beat(input frame_info_s f, input logic to_tx);
		frame_info_s idle;
		idle = ~f;
		idle.valid = 1'b0;
		@(negedge sys_clk);
		if (to_tx) tx_frame = f;
		else rx_frame = f;
		@(negedge sys_clk);
		if (to_tx) tx_frame = idle;
		else rx_frame = idle;
	endtask
endmodule
`default_nettype wire

// ===== bench/switch_port_control_test.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench for the per-port control logic
// ----------------------------------------------------------------
module switch_port_control_test;
	import port_ctrl_pkg::*;
	logic sys_clk, resetn, strap_pause_enable, soft_reset_cmd;
	logic duplex_full, link_resolved, reg_rvalid, rx_accept, rx_learn;
	logic tx_accept, tx_add_trailer, rx_strip_trailer, flow_control_en;
	logic back_pressure_en, queue_release;
	logic [1:0] switch_config_pins, stp_port_state;
	logic [5:0] egress_port_mask, rx_dest_ports;
	logic [15:0] reg_rdata;
	reg_req_s reg_req;
	frame_info_s rx_frame, tx_frame;
	int errors, total_checks, cycles;

	switch_port_control #(.port_index(4), .trailer_capable(1'b1)) uut (
		.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.switch_config_pins(switch_config_pins),
		.strap_pause_enable(strap_pause_enable),
		.soft_reset_cmd(soft_reset_cmd), .egress_port_mask(egress_port_mask),
		.duplex_full(duplex_full), .link_resolved(link_resolved),
		.rx_frame(rx_frame), .tx_frame(tx_frame), .rx_accept(rx_accept),
		.rx_learn(rx_learn), .rx_dest_ports(rx_dest_ports),
		.tx_accept(tx_accept), .tx_add_trailer(tx_add_trailer),
		.rx_strip_trailer(rx_strip_trailer),
		.flow_control_en(flow_control_en),
		.back_pressure_en(back_pressure_en),
		.queue_release(queue_release), .stp_port_state(stp_port_state));
	fwd_core_model core (.sys_clk(sys_clk), .rx_frame(rx_frame),
		.tx_frame(tx_frame));

	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			print_verdict;
		end
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict;
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkb(input string n, input logic e, input logic g);
		chk(n, {15'h0, e}, {15'h0, g});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic hard_reset(input logic [1:0] pins);
		switch_config_pins = pins;
		resetn = 1'b0;
		tick(10);
		resetn = 1'b1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge sys_clk);
		reg_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		int n;
		@(negedge sys_clk);
		reg_req.addr = a;
		reg_req.rd = 1'b1;
		@(negedge sys_clk);
		reg_req.rd = 1'b0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 3) begin
			@(negedge sys_clk);
			n++;
		end
		chkb("reg_rvalid", 1'b1, reg_rvalid);
		chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic sreset;
		@(negedge sys_clk);
		soft_reset_cmd = 1'b1;
		@(negedge sys_clk);
		soft_reset_cmd = 1'b0;
	endtask
	// single-beat frame: locked, multicast, management entry, ports
	function automatic frame_info_s fr(input logic l, input logic mc,
		input logic mg, input logic [5:0] d);
		return {3'h7, l, mc, mg, d};
	endfunction
	task automatic frm(input frame_info_s f, input logic a, input logic l,
		input logic t);
		core.beat(f, 1'b0);
		chkb("rx_accept", a, rx_accept);
		chkb("rx_learn", l, rx_learn);
		core.beat(f, 1'b1);
		chkb("tx_accept", t, tx_accept);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs_pause;
		wr(port_control_off, 16'hffff);
		rd(port_control_off, 16'hc983);
		chkb("tx_add_trailer", 1'b1, tx_add_trailer);
		chkb("rx_strip_trailer", 1'b1, rx_strip_trailer);
		wr(port_control_off, 16'h0000);
		rd(port_control_off, 16'h8000);
		wr(reserved_port_word_off, 16'hffff);
		rd(reserved_port_word_off, 16'h0000);
		rd(port_control_off, 16'h8000);
		chkb("flow_control_en", 1'b1, flow_control_en);
		duplex_full = 1'b0;
		tick(2);
		chkb("back_pressure_en", 1'b1, back_pressure_en);
		chkb("flow_control_en", 1'b0, flow_control_en);
		wr(port_control_off, 16'h0000);
		tick(2);
		chkb("back_pressure_en", 1'b0, back_pressure_en);
		chkb("tx_add_trailer", 1'b0, tx_add_trailer);
		chkb("rx_strip_trailer", 1'b0, rx_strip_trailer);
		strap_pause_enable = 1'b1;
		tick(2);
		chkb("back_pressure_en", 1'b1, back_pressure_en);
		link_resolved = 1'b0;
		tick(2);
		chkb("back_pressure_en", 1'b0, back_pressure_en);
		link_resolved = 1'b1;
		strap_pause_enable = 1'b0;
		duplex_full = 1'b1;
	endtask
	task automatic t_states;
		frame_info_s m, p;
		m = fr(1'b0, 1'b1, 1'b1, 6'h3f);
		p = fr(1'b0, 1'b0, 1'b1, 6'h3f);
		for (int s = 0; s < 4; s++) begin
			wr(port_control_off, {14'h0, s[1:0]});
			tick(2);
			chkb("queue_release", s == 0, queue_release);
			chk("stp_port_state", {14'h0, s[1:0]},
				{14'h0, stp_port_state});
			frm(m, s != 0, s > 1, s != 0);
			frm(p, s == 3, s > 1, s == 3);
		end
	endtask
	task automatic t_mid;
		frame_info_s f;
		f = fr(1'b0, 1'b0, 1'b0, 6'h3f);
		f.eof = 1'b0;
		core.beat(f, 1'b0);
		wr(port_control_off, 16'h0000);
		f.sof = 1'b0;
		f.eof = 1'b1;
		core.beat(f, 1'b0);
		chkb("rx_accept", 1'b1, rx_accept);
		core.beat(fr(1'b0, 1'b0, 1'b0, 6'h3f), 1'b0);
		chkb("rx_accept", 1'b0, rx_accept);
	endtask
	task automatic t_bypass;
		wr(port_control_off, 16'h0003);
		core.beat(fr(1'b1, 1'b0, 1'b0, 6'h3f), 1'b0);
		chk("rx_dest_ports", 16'h000f, {10'h0, rx_dest_ports});
		wr(port_control_off, 16'h0083);
		core.beat(fr(1'b1, 1'b0, 1'b0, 6'h3f), 1'b0);
		chk("rx_dest_ports", 16'h003f, {10'h0, rx_dest_ports});
		core.beat(fr(1'b0, 1'b0, 1'b0, 6'h3f), 1'b0);
		chk("rx_dest_ports", 16'h000f, {10'h0, rx_dest_ports});
	endtask
	task automatic t_soft;
		sreset;
		rd(port_control_off, 16'h0000);
		hard_reset(2'h1);
		rd(port_control_off, 16'h0003);
		wr(port_control_off, 16'h0000);
		sreset;
		rd(port_control_off, 16'h0003);
	endtask
	// main sequence
	initial begin
		errors = 0;
		total_checks = 0;
		cycles = 0;
		reg_req = '0;
		strap_pause_enable = 1'b0;
		soft_reset_cmd = 1'b0;
		egress_port_mask = 6'h0f;
		duplex_full = 1'b1;
		link_resolved = 1'b1;
		hard_reset(2'h0);
		rd(port_control_off, 16'h0000);
		t_regs_pause;
		t_states;
		t_mid;
		t_bypass;
		t_soft;
		print_verdict;
	end
endmodule
`default_nettype wire
